// >>> src/dsau_params.svh
// constants for the data space access unit
`ifndef DSAU_PARAMS_SVH
`define DSAU_PARAMS_SVH
`define DSAU_EA_W 16
`define DSAU_RAM_WORDS 1024
`define DSAU_RAM_BASE 16'h0800
`define DSAU_NEAR_LAST 16'h1FFF
`define DSAU_NEAR_W 13
`define DSAU_SFR_LAST 16'h07FF
`define DSAU_SFR_BLK_W 5
`define DSAU_SFR_BLKS 64
`define DSAU_SFR_BLK_MAP 64'h0000_0000_0000_0000
`define DSAU_WIN_BIT 15
`define DSAU_WIN_EN_BIT 2
`define DSAU_INC_BYTE 16'h0001
`define DSAU_INC_WORD 16'h0002
`endif

// >>> src/dsau_pkg.sv
// types shared by the data space access unit
package dsau_pkg;
    typedef enum logic [1:0] {
        DSAU_REG_NONE,
        DSAU_REG_SIGN_EXT,
        DSAU_REG_ZERO_EXT,
        DSAU_REG_BYTE_LOAD
    } dsau_regop_t;
    typedef enum logic [1:0] {
        DSAU_TGT_NONE,
        DSAU_TGT_SFR,
        DSAU_TGT_RAM,
        DSAU_TGT_WIN
    } dsau_tgt_t;
endpackage : dsau_pkg

// >>> src/dsau_decode.sv
// region decode of one effective address
`timescale 1ns/1ps
`include "dsau_params.svh"
module dsau_decode (
    // address
    input wire logic [15:0] effective_address_i,
    input wire logic [`DSAU_SFR_BLKS-1:0] sfr_blk_map_i,
    // result
    output dsau_pkg::dsau_tgt_t target_o,
    output logic near_o
);
    localparam logic [15:0] RAM_END = 16'(`DSAU_RAM_BASE + 2 * `DSAU_RAM_WORDS);
    logic [5:0] blk;
    assign blk = effective_address_i[10:`DSAU_SFR_BLK_W];
    assign near_o = effective_address_i <= `DSAU_NEAR_LAST;
    always_comb begin
        target_o = dsau_pkg::DSAU_TGT_NONE;
        if (effective_address_i[`DSAU_WIN_BIT]) begin
            target_o = dsau_pkg::DSAU_TGT_WIN;
        end else if (effective_address_i <= `DSAU_SFR_LAST) begin
            // 32-byte blocks without registers read as zero
            if (sfr_blk_map_i[blk]) begin
                target_o = dsau_pkg::DSAU_TGT_SFR;
            end
        end else if (effective_address_i < RAM_END) begin
            target_o = dsau_pkg::DSAU_TGT_RAM;
        end
    end
endmodule : dsau_decode

// >>> src/dsau_top.sv
// data space access unit: address decode, lane steering, ram, traps
//
// Summary of operation
// - effective addresses are 16 bits, each names one byte, 64 Kbytes.
// - top bit clear goes to memory, set goes to program window.
// - 1024 words of ram; reads outside implemented area return zero.
// - 16-bit words, low byte at even address, high byte at odd.
// - pointer post-increment is one for bytes, two for words.
// - byte read fetches the word, selects by bit 0, returns low lane.
// - shared word decode, separate lane strobes; byte write hits one lane.
// - word access at odd address raises an address error trap.
// - misaligned read completes, misaligned write is suppressed, then trap.
// - byte load into a working register changes only its low byte.
// - sign extend eight to sixteen bits; zero extend clears high byte.
// - 0000h to 1FFFh is near region, 13-bit field; ram lies inside.
// - move instructions reach the whole space with a 16-bit field.
// - special function registers lie in 0000h to 07FFh.
// - special function register reads return what the peripheral drives; the block map marks all 64 blocks implemented.
// - register region is decoded in 32-byte blocks.
// - separate read and write address generators.
// - program window visible only while the enable bit is set.
`timescale 1ns/1ps
`include "dsau_params.svh"
module dsau_top #(
    parameter int RAM_WORDS = `DSAU_RAM_WORDS
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // read address generator
    input wire logic rd_req_i,
    input wire logic rd_byte_i,
    input wire logic rd_direct_i,
    input wire logic rd_direct_near_i,
    input wire logic [15:0] rd_direct_addr_i,
    input wire logic [15:0] source_pointer_register_i,
    input wire logic rd_post_inc_i,
    // write address generator
    input wire logic wr_req_i,
    input wire logic wr_byte_i,
    input wire logic [15:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_post_inc_i,
    // core control
    input wire logic [15:0] core_control_register_i,
    // program window and special function registers
    input wire logic [15:0] win_rdata_i,
    input wire logic [15:0] sfr_rdata_i,
    // working register operation
    input wire dsau_pkg::dsau_regop_t reg_op_i,
    input wire logic [15:0] reg_old_i,
    // read results, pointer updates and register result
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    output logic [15:0] rd_ptr_next_o,
    output logic [15:0] wr_ptr_next_o,
    output logic [15:0] reg_new_o,
    // peripheral side
    output logic win_rd_o,
    output logic [15:0] win_addr_o,
    output logic sfr_rd_o,
    output logic sfr_wr_o,
    output logic [15:0] sfr_addr_o,
    output logic [1:0] sfr_lane_we_o,
    output logic [15:0] sfr_wdata_o,
    // exception logic
    output logic addr_trap_o,
    output logic addr_trap_wr_o
);
    initial begin
        // decoder region and index width are sized by the macro, so only that depth is served
        if (RAM_WORDS != `DSAU_RAM_WORDS) begin
            $error("RAM_WORDS out of range");
        end
    end

    // ------------------------------------------------------------
    // address generation
    // ------------------------------------------------------------
    logic [15:0] rd_ea;
    dsau_pkg::dsau_tgt_t rd_tgt;
    dsau_pkg::dsau_tgt_t wr_tgt;
    logic rd_near;
    logic wr_near;
    logic win_en;
    logic rd_mis;
    logic wr_mis;
    logic [15:0] rd_step;
    logic [15:0] wr_step;
    localparam logic [`DSAU_SFR_BLKS-1:0] BLK_MAP = ~`DSAU_SFR_BLK_MAP;

    function automatic logic [15:0] step_f(input logic is_byte);
        step_f = is_byte ? `DSAU_INC_BYTE : `DSAU_INC_WORD;
    endfunction : step_f

    // near direct field holds 13 bits; move form carries all 16
    assign rd_ea = !rd_direct_i ? source_pointer_register_i :
        (rd_direct_near_i ? {3'h0, rd_direct_addr_i[`DSAU_NEAR_W-1:0]}
                          : rd_direct_addr_i);
    assign win_en = core_control_register_i[`DSAU_WIN_EN_BIT];
    assign rd_mis = rd_req_i && !rd_byte_i && rd_ea[0];
    assign wr_mis = wr_req_i && !wr_byte_i && wr_addr_i[0];
    assign rd_step = step_f(rd_byte_i);
    assign wr_step = step_f(wr_byte_i);

    // two independent decoders, one per generator
    dsau_decode u_rd_dec (
        .effective_address_i(rd_ea),
        .sfr_blk_map_i(BLK_MAP),
        .target_o(rd_tgt),
        .near_o(rd_near)
    );
    dsau_decode u_wr_dec (
        .effective_address_i(wr_addr_i),
        .sfr_blk_map_i(BLK_MAP),
        .target_o(wr_tgt),
        .near_o(wr_near)
    );

    // ------------------------------------------------------------
    // data memory
    // ------------------------------------------------------------
    logic [7:0] ram_lo [RAM_WORDS];
    logic [7:0] ram_hi [RAM_WORDS];
    logic [15:0] ram_rdata_q;
    logic [9:0] rd_idx;
    logic [9:0] wr_idx;
    logic [1:0] lane_we;
    logic wr_ok;
    logic ram_rd_q;
    logic [15:0] rd_ea_q;
    logic rd_byte_q;
    dsau_pkg::dsau_tgt_t rd_tgt_q;

    assign rd_idx = 10'((rd_ea - `DSAU_RAM_BASE) >> 1);
    assign wr_idx = 10'((wr_addr_i - `DSAU_RAM_BASE) >> 1);
    assign wr_ok = wr_req_i && !wr_mis;
    // byte write picks the lane matching bit 0, word writes both
    assign lane_we = !wr_ok ? 2'h0 :
        (wr_byte_i ? (wr_addr_i[0] ? 2'h2 : 2'h1) : 2'h3);

    always_ff @(posedge mclk_i) begin
        if (wr_tgt == dsau_pkg::DSAU_TGT_RAM && lane_we[0]) begin
            ram_lo[wr_idx] <= wr_byte_i ? wr_data_i[7:0] : wr_data_i[7:0];
        end
        if (wr_tgt == dsau_pkg::DSAU_TGT_RAM && lane_we[1]) begin
            ram_hi[wr_idx] <= wr_byte_i ? wr_data_i[7:0] : wr_data_i[15:8];
        end
        if (rd_req_i && rd_tgt == dsau_pkg::DSAU_TGT_RAM) begin
            ram_rdata_q <= {ram_hi[rd_idx], ram_lo[rd_idx]};
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ram_rd_q <= 1'b0;
            rd_ea_q <= 16'h0000;
            rd_byte_q <= 1'b0;
            rd_tgt_q <= dsau_pkg::DSAU_TGT_NONE;
        end else begin
            ram_rd_q <= rd_req_i;
            rd_ea_q <= rd_ea;
            rd_byte_q <= rd_byte_i;
            rd_tgt_q <= rd_tgt;
        end
    end

    // ------------------------------------------------------------
    // peripheral side, registered requests
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            win_rd_o <= 1'b0;
            win_addr_o <= 16'h0000;
            sfr_rd_o <= 1'b0;
            sfr_wr_o <= 1'b0;
            sfr_addr_o <= 16'h0000;
            sfr_lane_we_o <= 2'h0;
            sfr_wdata_o <= 16'h0000;
        end else begin
            // window closed while the enable bit is clear
            win_rd_o <= rd_req_i && rd_tgt == dsau_pkg::DSAU_TGT_WIN && win_en;
            win_addr_o <= rd_ea;
            sfr_rd_o <= rd_req_i && rd_tgt == dsau_pkg::DSAU_TGT_SFR;
            sfr_wr_o <= wr_ok && wr_tgt == dsau_pkg::DSAU_TGT_SFR;
            sfr_addr_o <= (wr_req_i && wr_tgt == dsau_pkg::DSAU_TGT_SFR) ? wr_addr_i : rd_ea;
            sfr_lane_we_o <= (wr_tgt == dsau_pkg::DSAU_TGT_SFR) ? lane_we : 2'h0;
            sfr_wdata_o <= wr_byte_i ? {wr_data_i[7:0], wr_data_i[7:0]} : wr_data_i;
        end
    end

    // ------------------------------------------------------------
    // read data return, two cycles after the request
    // ------------------------------------------------------------
    logic [15:0] src_word;
    logic [15:0] rd_word;
    always_comb begin
        src_word = 16'h0000;
        case (rd_tgt_q)
            dsau_pkg::DSAU_TGT_RAM: src_word = ram_rdata_q;
            dsau_pkg::DSAU_TGT_SFR: src_word = sfr_rdata_i;
            dsau_pkg::DSAU_TGT_WIN: src_word = win_en ? win_rdata_i : 16'h0000;
            default: src_word = 16'h0000;
        endcase
        rd_word = !rd_byte_q ? src_word :
            {8'h00, rd_ea_q[0] ? src_word[15:8] : src_word[7:0]};
    end

    // ------------------------------------------------------------
    // working register update
    // ------------------------------------------------------------
    logic [15:0] reg_new;
    always_comb begin
        case (reg_op_i)
            dsau_pkg::DSAU_REG_SIGN_EXT: reg_new = {{8{reg_old_i[7]}}, reg_old_i[7:0]};
            dsau_pkg::DSAU_REG_ZERO_EXT: reg_new = {8'h00, reg_old_i[7:0]};
            dsau_pkg::DSAU_REG_BYTE_LOAD: reg_new = {reg_old_i[15:8], rd_word[7:0]};
            default: reg_new = reg_old_i;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= 16'h0000;
            reg_new_o <= 16'h0000;
        end else begin
            rd_valid_o <= ram_rd_q;
            rd_data_o <= rd_word;
            reg_new_o <= reg_new;
        end
    end

    // ------------------------------------------------------------
    // pointer post-modify and traps
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_ptr_next_o <= 16'h0000;
            wr_ptr_next_o <= 16'h0000;
        end else begin
            rd_ptr_next_o <= rd_post_inc_i ? 16'(source_pointer_register_i + rd_step)
                                           : source_pointer_register_i;
            wr_ptr_next_o <= wr_post_inc_i ? 16'(wr_addr_i + wr_step) : wr_addr_i;
        end
    end

    // write side reported when both misalign in the same cycle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_trap_o <= 1'b0;
            addr_trap_wr_o <= 1'b0;
        end else begin
            addr_trap_o <= rd_mis || wr_mis;
            addr_trap_wr_o <= wr_mis;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_trap_pulse: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (rd_mis || wr_mis) |=> addr_trap_o && addr_trap_wr_o == $past(wr_mis))
        else $error("trap not raised for misaligned access");
    a_trap_cause: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        addr_trap_o |-> $past(rd_mis || wr_mis))
        else $error("trap without misaligned access");
    a_wr_suppress: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (wr_mis && wr_tgt == dsau_pkg::DSAU_TGT_SFR) |=> !sfr_wr_o)
        else $error("misaligned write not suppressed");
    a_byte_lane: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (wr_req_i && wr_byte_i && wr_tgt == dsau_pkg::DSAU_TGT_SFR)
        |=> sfr_lane_we_o == ($past(wr_addr_i[0]) ? 2'h2 : 2'h1))
        else $error("byte write strobes wrong lane");
    a_step_size: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        rd_post_inc_i |=> rd_ptr_next_o ==
        16'($past(source_pointer_register_i) + ($past(rd_byte_i) ? 16'h0001 : 16'h0002)))
        else $error("post increment not scaled");
    a_byte_read: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (rd_valid_o && $past(rd_byte_q)) |-> rd_data_o[15:8] == 8'h00)
        else $error("byte read high lane not zero");
    a_unimpl_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (rd_req_i && rd_tgt == dsau_pkg::DSAU_TGT_NONE) |=> ##1 rd_data_o == 16'h0000)
        else $error("unimplemented read not zero");
    a_win_gate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        win_rd_o |-> $past(win_en) && $past(rd_ea[15]))
        else $error("window read while closed");
    a_zero_ext: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        reg_op_i == dsau_pkg::DSAU_REG_ZERO_EXT |=> reg_new_o[15:8] == 8'h00)
        else $error("zero extend left high byte");
    a_ram_near: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (rd_tgt != dsau_pkg::DSAU_TGT_RAM || rd_near)
        && (wr_tgt != dsau_pkg::DSAU_TGT_RAM || wr_near))
        else $error("ram decoded outside the near region");
    a_win_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (rd_req_i && rd_tgt == dsau_pkg::DSAU_TGT_WIN && !win_en) ##1 !win_en
        |=> rd_data_o == 16'h0000)
        else $error("closed window read not zero");
    a_word_lanes: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (wr_ok && !wr_byte_i && wr_tgt == dsau_pkg::DSAU_TGT_SFR)
        |=> sfr_wr_o && sfr_lane_we_o == 2'h3)
        else $error("word write lanes wrong");
endmodule : dsau_top

// >>> bench/dsau_periph_model.sv
// peripheral register and program window model facing the access unit
`timescale 1ns/1ps
module dsau_periph_model (
    // strobes and addresses from the unit
    input wire logic sfr_rd_i,
    input wire logic [15:0] sfr_addr_i,
    input wire logic win_rd_i,
    input wire logic [15:0] win_addr_i,
    // read data back to the unit
    output logic [15:0] sfr_rdata_o,
    output logic [15:0] win_rdata_o
);
    logic [15:0] sfr_val;
    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_comb begin
        sfr_val = {8'hC3, sfr_addr_i[7:0]};
        // blocks 400h to 5FFh hold no registers and read zero
        if (sfr_addr_i[10:9] == 2'b10) begin
            sfr_val = 16'h0000;
        end
        // unstrobed register data and strobed window data are inverted so a late or early sample shows up
        sfr_rdata_o = sfr_rd_i ? sfr_val : ~sfr_val;
        win_rdata_o = win_rd_i ? ~win_addr_i : win_addr_i;
    end
endmodule : dsau_periph_model

// >>> bench/tb_data_space_access_unit.sv
// self-checking bench for the data space access unit
`timescale 1ns/1ps
module tb_data_space_access_unit;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rd_req, rd_byte, rd_dir, rd_near, rd_pinc, wr_req, wr_byte, wr_pinc;
    logic [15:0] rd_daddr, src_ptr, wr_addr, wr_data, core_ctl, reg_old;
    logic [15:0] win_rdata, sfr_rdata, rd_data, rd_pn, wr_pn, reg_new, win_addr, sfr_addr;
    dsau_pkg::dsau_regop_t reg_op;
    logic rd_valid, win_rd, sfr_rd, trap, trap_wr, saw_win, saw_wr, sfr_wr;
    logic [1:0] sfr_lane;
    logic [15:0] sfr_wdata;
    logic [15:0] d;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    int traps;
    always #5 mclk_i = ~mclk_i;
    dsau_top dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .rd_req_i(rd_req), .rd_byte_i(rd_byte),
        .rd_direct_i(rd_dir), .rd_direct_near_i(rd_near), .rd_direct_addr_i(rd_daddr),
        .source_pointer_register_i(src_ptr), .rd_post_inc_i(rd_pinc), .wr_req_i(wr_req),
        .wr_byte_i(wr_byte), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
        .wr_post_inc_i(wr_pinc), .core_control_register_i(core_ctl),
        .win_rdata_i(win_rdata), .sfr_rdata_i(sfr_rdata), .reg_op_i(reg_op),
        .reg_old_i(reg_old), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
        .rd_ptr_next_o(rd_pn), .wr_ptr_next_o(wr_pn), .reg_new_o(reg_new),
        .win_rd_o(win_rd), .win_addr_o(win_addr), .sfr_rd_o(sfr_rd), .sfr_wr_o(sfr_wr),
        .sfr_addr_o(sfr_addr), .sfr_lane_we_o(sfr_lane), .sfr_wdata_o(sfr_wdata),
        .addr_trap_o(trap),
        .addr_trap_wr_o(trap_wr));
    dsau_periph_model partner (.sfr_rd_i(sfr_rd), .sfr_addr_i(sfr_addr), .win_rd_i(win_rd),
        .win_addr_i(win_addr), .sfr_rdata_o(sfr_rdata), .win_rdata_o(win_rdata));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // read: take edge, strobes one cycle later, data two cycles later
    task automatic rd(input logic [15:0] a, input logic byt, output logic [15:0] q);
        int n;
        @(posedge mclk_i);
        src_ptr <= a;
        rd_daddr <= a;
        rd_byte <= byt;
        rd_req <= 1'b1;
        @(posedge mclk_i);
        rd_req <= 1'b0;
        n = 0;
        saw_win = 1'b0;
        traps = 0;
        #1;
        // strobes and trap stand only in the cycle after the take edge
        do begin
            saw_win |= win_rd;
            if (trap === 1'b1) begin
                traps++;
                saw_wr = trap_wr;
            end
            n++;
            @(posedge mclk_i);
            #1;
        end while (rd_valid !== 1'b1 && n < 4);
        chk({15'h0000, rd_valid}, 16'h0001);
        q = rd_data;
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic byt);
        @(posedge mclk_i);
        wr_addr <= a;
        wr_data <= v;
        wr_byte <= byt;
        wr_req <= 1'b1;
        @(posedge mclk_i);
        wr_req <= 1'b0;
    endtask : wr
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_lanes();
        wr(16'h0800, 16'h1234, 1'b0);
        rd(16'h0801, 1'b1, d);
        chk(d, 16'h0012);
        rd(16'h0800, 1'b1, d);
        chk(d, 16'h0034);
        wr(16'h0801, 16'h00AB, 1'b1);
        rd(16'h0801, 1'b1, d);
        @(posedge mclk_i);
        reg_op <= dsau_pkg::DSAU_REG_BYTE_LOAD;
        reg_old <= 16'hCDEF;
        @(posedge mclk_i);
        reg_op <= dsau_pkg::DSAU_REG_NONE;
        #1;
        chk(reg_new, 16'hCDAB);
        rd(16'h0800, 1'b0, d);
        chk(d, 16'hAB34);
        $display("lanes done");
    endtask : t_lanes
    task automatic t_extend();
        @(posedge mclk_i);
        reg_op <= dsau_pkg::DSAU_REG_SIGN_EXT;
        reg_old <= 16'h0080;
        @(posedge mclk_i);
        reg_op <= dsau_pkg::DSAU_REG_ZERO_EXT;
        reg_old <= 16'hAB80;
        #1;
        chk(reg_new, 16'hFF80);
        @(posedge mclk_i);
        reg_op <= dsau_pkg::DSAU_REG_NONE;
        #1;
        chk(reg_new, 16'h0080);
        $display("extend done");
    endtask : t_extend
    task automatic t_regions();
        rd(16'h1000, 1'b0, d);
        chk(d, 16'h0000);
        rd(16'h0044, 1'b0, d);
        chk(d, 16'hC344);
        rd(16'h0400, 1'b0, d);
        chk(d, 16'h0000);
        rd(16'h8000, 1'b0, d);
        chk(d, 16'h0000);
        @(posedge mclk_i);
        core_ctl <= 16'h0004;
        rd(16'h8000, 1'b0, d);
        chk({15'h0000, saw_win}, 16'h0001);
        chk(d, 16'h7FFF);
        @(posedge mclk_i);
        core_ctl <= 16'h0000;
        $display("regions done");
    endtask : t_regions
    task automatic t_direct();
        @(posedge mclk_i);
        rd_dir <= 1'b1;
        rd(16'h0800, 1'b0, d);
        chk(d, 16'hAB34);
        rd(16'hE800, 1'b0, d);
        chk(d, 16'h0000);
        @(posedge mclk_i);
        rd_near <= 1'b1;
        rd(16'hE800, 1'b0, d);
        chk(d, 16'hAB34);
        @(posedge mclk_i);
        rd_dir <= 1'b0;
        rd_near <= 1'b0;
        $display("direct done");
    endtask : t_direct
    task automatic t_trap();
        // misaligned word write into the word at 0800h, which must keep its value
        wr(16'h0801, 16'h5555, 1'b0);
        #1;
        chk({14'h0000, trap, trap_wr}, 16'h0003);
        rd(16'h0800, 1'b0, d);
        chk(d, 16'hAB34);
        saw_wr = 1'b1;
        rd(16'h0805, 1'b0, d);
        chk(16'(traps), 16'h0001);
        chk({15'h0000, saw_wr}, 16'h0000);
        $display("trap done");
    endtask : t_trap
    task automatic t_sfr_wr();
        wr(16'h0045, 16'h00A5, 1'b1);
        #1;
        chk({sfr_wr, 5'h00, sfr_lane, 8'h00}, 16'h8200);
        chk(sfr_wdata, 16'hA5A5);
        chk(sfr_addr, 16'h0045);
        wr(16'h0046, 16'h1234, 1'b0);
        #1;
        chk({sfr_wr, 5'h00, sfr_lane, 8'h00}, 16'h8300);
        chk(sfr_wdata, 16'h1234);
        wr(16'h0045, 16'h1234, 1'b0);
        #1;
        chk({14'h0000, sfr_wr, trap}, 16'h0001);
        $display("sfr write done");
    endtask : t_sfr_wr
    task automatic t_postinc();
        for (int b = 0; b < 2; b++) begin
            @(posedge mclk_i);
            src_ptr <= 16'h0840;
            rd_byte <= b[0];
            rd_pinc <= 1'b1;
            rd_req <= 1'b1;
            wr_addr <= 16'h0850;
            wr_data <= 16'h0000;
            wr_byte <= b[0];
            wr_pinc <= 1'b1;
            wr_req <= 1'b1;
            @(posedge mclk_i);
            rd_req <= 1'b0;
            wr_req <= 1'b0;
            @(posedge mclk_i);
            #1;
            chk(rd_pn, b ? 16'h0841 : 16'h0842);
            chk(wr_pn, b ? 16'h0851 : 16'h0852);
            @(posedge mclk_i);
        end
        rd_pinc <= 1'b0;
        wr_pinc <= 1'b0;
        $display("postinc done");
    endtask : t_postinc
    // ----------------------------------------
    // main sequence and timeout
    // ----------------------------------------
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        {rd_req, rd_byte, rd_dir, rd_near, rd_pinc, wr_req, wr_byte, wr_pinc} = 8'h00;
        {rd_daddr, src_ptr, wr_addr, wr_data, core_ctl, reg_old} = '0;
        reg_op = dsau_pkg::DSAU_REG_NONE;
        repeat (2) @(posedge mclk_i);
        #1;
        chk({14'h0000, rd_valid, trap}, 16'h0000);
        @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_lanes();
        t_extend();
        t_regions();
        t_direct();
        t_trap();
        t_sfr_wr();
        t_postinc();
        final_report();
    end
endmodule : tb_data_space_access_unit
